// [design/nand_lock_host_pkg.sv]
package nand_lock_host_pkg;
   localparam logic [7:0] CMD_LOCK        = 8'h2a;
   localparam logic [7:0] CMD_UNLOCK_LO   = 8'h23;
   localparam logic [7:0] CMD_UNLOCK_HI   = 8'h24;
   localparam logic [7:0] CMD_LOCK_TIGHT  = 8'h2c;
   localparam logic [7:0] CMD_LOCK_STATUS = 8'h7a;
   localparam logic [7:0] CMD_STATUS      = 8'h70;
   // apb register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_START  = 8'h04;
   localparam logic [7:0] REG_END    = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_RESULT = 8'h10;
   // ctrl fields: go pulse bit, op code bits, wp pulse, preset level
   localparam int CTRL_GO_BIT     = 0;
   localparam int CTRL_OP_LSB     = 1;
   localparam int CTRL_WP_BIT     = 4;
   localparam int CTRL_PRESET_BIT = 5;
   localparam logic [2:0] OP_LOCK = 3'h0;
   localparam logic [2:0] OP_UNLOCK = 3'h1;
   localparam logic [2:0] OP_TIGHT  = 3'h2;
   localparam logic [2:0] OP_QUERY  = 3'h3;
   localparam logic [2:0] OP_WPPULSE = 3'h4;
   // status fields
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_RB_BIT    = 1;
   localparam int STAT_READY_BIT = 2;
   localparam int STAT_UNLOCK_BIT = 2;
   localparam int STAT_LOCK_BIT   = 1;
   localparam int STAT_TIGHT_BIT  = 0;
   // timing
   localparam int CLK_NS        = 100;
   localparam int POWERUP_US    = 10;
   localparam int POWERUP_CYC   = (POWERUP_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int STROBE_CYC    = 1;
   localparam int WP_PULSE_CYC  = 2;
   // output flop plus two sync flops before a read byte can be trusted
   localparam int RD_SETTLE_CYC = 3;
   localparam int BLOCK_AW      = 11;
endpackage : nand_lock_host_pkg

// [design/nand_pin_seq.sv]
`timescale 1ns/1ps
`default_nettype none
// one cycle on the nand pins: a latched command/address byte or a read
module nand_pin_seq
   import nand_lock_host_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       clk_en,
   input  wire logic       start,
   input  wire logic       is_cmd,
   input  wire logic       is_read,
   input  wire logic [7:0] byte_in,
   input  wire logic [7:0] io_sync,
   output logic            done,
   output logic [7:0]      rd_byte,
   output logic            cle,
   output logic            ale,
   output logic            we_n,
   output logic            re_n,
   output logic [7:0]      io_out,
   output logic            io_oe
);
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_LOW  = 4'b0010,
      S_HIGH = 4'b0100,
      S_DONE = 4'b1000
   } seq_t;
   seq_t st_q;
   logic rd_q;
   logic [1:0] dly_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q    <= S_IDLE;
         cle     <= 1'b0;
         ale     <= 1'b0;
         we_n    <= 1'b1;
         re_n    <= 1'b1;
         io_out  <= 8'h00;
         io_oe   <= 1'b0;
         rd_q    <= 1'b0;
         dly_q   <= 2'd0;
         done    <= 1'b0;
         rd_byte <= 8'h00;
      end else if (clk_en) begin
         done <= 1'b0;
         unique case (st_q)
            S_IDLE: begin
               if (start) begin
                  rd_q   <= is_read;
                  dly_q  <= 2'd0;
                  cle    <= is_cmd & ~is_read;
                  ale    <= ~is_cmd & ~is_read;
                  io_out <= byte_in;
                  io_oe  <= ~is_read;
                  we_n   <= is_read;
                  re_n   <= ~is_read;
                  st_q   <= S_LOW;
               end
            end
            S_LOW: begin
               // reads keep the strobe low until the byte has crossed both sync flops
               if (rd_q && dly_q != 2'(RD_SETTLE_CYC)) begin
                  dly_q <= dly_q + 2'd1;
               end else begin
                  we_n <= 1'b1;
                  re_n <= 1'b1;
                  if (rd_q) rd_byte <= io_sync;
                  st_q <= S_HIGH;
               end
            end
            S_HIGH: begin
               cle   <= 1'b0;
               ale   <= 1'b0;
               io_oe <= 1'b0;
               done  <= 1'b1;
               st_q  <= S_DONE;
            end
            S_DONE: st_q <= S_IDLE;
         endcase
      end
   end

   // a command byte must still stand with cle when the write strobe rises
   sequence cmd_strobe_s;
      clk_en && cle && !we_n && io_oe;
   endsequence
   sequence cmd_latch_s;
      cle && we_n && io_oe;
   endsequence
   chk_cmd_latch: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_strobe_s |=> cmd_latch_s)
      else $error("command byte released before its latch edge");
endmodule : nand_pin_seq
`default_nettype wire

// [design/nand_lock_host.sv]
`timescale 1ns/1ps
`default_nettype none
module nand_lock_host
   import nand_lock_host_pkg::*;
#(
   parameter int BLOCK_W      = BLOCK_AW,
   parameter int POWERUP_WAIT = POWERUP_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             cle,
   output logic             ale,
   output logic             ce_n,
   output logic             we_n,
   output logic             read_enable_n,
   output logic             write_protect_n,
   output logic             lock_preset_pin,
   output logic [7:0]       io_out,
   output logic             io_oe,
   input  wire logic [7:0]  io_in,
   input  wire logic        ready_busy_n
);
   import nand_lock_host_pkg::*;

   typedef enum logic [7:0] {
      H_PWRUP = 8'b0000_0001,
      H_IDLE  = 8'b0000_0010,
      H_CMD   = 8'b0000_0100,
      H_ADDR  = 8'b0000_1000,
      H_CMD2  = 8'b0001_0000,
      H_ADDR2 = 8'b0010_0000,
      H_READ  = 8'b0100_0000,
      H_WP    = 8'b1000_0000
   } host_t;

   host_t              st_q;
   logic [7:0]         io_s1_q, io_s2_q;
   logic               rb_s1_q, rb_s2_q;
   logic [2:0]         op_q;
   logic [BLOCK_W-1:0] start_q, end_q;
   logic [15:0]        wait_q;
   logic               go_q, err_q, preset_q;
   logic [7:0]         result_q;
   logic               idx_q, seq_busy_q;
   logic               seq_start, seq_cmd, seq_read, seq_done;
   logic [7:0]         seq_byte, seq_rd;
   logic               seq_cle, seq_ale, seq_we, seq_re, seq_oe;
   logic [7:0]         seq_io;
   logic               wr_acc, rd_acc;
   logic [15:0]        start_w, end_w;

   assign wr_acc  = psel & penable & pwrite;
   assign rd_acc  = psel & penable & ~pwrite;
   assign start_w = 16'(start_q);
   assign end_w   = 16'(end_q);

   // pins from the device pass two flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_s1_q <= 8'h00;
         io_s2_q <= 8'h00;
         rb_s1_q <= 1'b0;
         rb_s2_q <= 1'b0;
      end else if (clk_en) begin
         io_s1_q <= io_in;
         io_s2_q <= io_s1_q;
         rb_s1_q <= ready_busy_n;
         rb_s2_q <= rb_s1_q;
      end
   end

   // apb slave: zero wait states, unmapped reads zero with pslverr
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         prdata   <= 32'h0000_0000;
         go_q     <= 1'b0;
         op_q     <= OP_LOCK;
         preset_q <= 1'b1;
         start_q  <= '0;
         end_q    <= '0;
      end else if (clk_en) begin
         go_q    <= 1'b0;
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel & ~penable & ~pwrite) begin
            unique case (paddr)
               REG_CTRL:   prdata <= {26'h0, preset_q, 5'h0};
               REG_START:  prdata <= {16'h0, start_w};
               REG_END:    prdata <= {16'h0, end_w};
               REG_STATUS: prdata <= {29'h0, st_q == H_IDLE, rb_s2_q, st_q != H_IDLE};
               REG_RESULT: prdata <= {24'h0, result_q};
               default: begin
                  prdata  <= 32'h0000_0000;
                  pslverr <= 1'b1;
               end
            endcase
         end
         if (psel & ~penable & pwrite) begin
            unique case (paddr)
               REG_CTRL: begin
                  go_q     <= pwdata[CTRL_GO_BIT];
                  op_q     <= pwdata[CTRL_OP_LSB +: 3];
                  preset_q <= pwdata[CTRL_PRESET_BIT];
               end
               REG_START: start_q <= pwdata[BLOCK_W-1:0];
               REG_END:   end_q   <= pwdata[BLOCK_W-1:0];
               default:   pslverr <= 1'b1;
            endcase
         end
      end
   end

   assign seq_start = (st_q inside {H_CMD, H_ADDR, H_CMD2, H_ADDR2, H_READ})
                      & wait_q == 16'h0000;
   assign seq_cmd   = st_q inside {H_CMD, H_CMD2};
   assign seq_read  = st_q == H_READ;

   always_comb begin
      seq_byte = 8'h00;
      unique case (st_q)
         H_CMD: begin
            unique case (op_q)
               OP_UNLOCK: seq_byte = CMD_UNLOCK_LO;
               OP_TIGHT:  seq_byte = CMD_LOCK_TIGHT;
               OP_QUERY:  seq_byte = CMD_LOCK_STATUS;
               default:   seq_byte = CMD_LOCK;
            endcase
         end
         H_CMD2:  seq_byte = CMD_UNLOCK_HI;
         H_ADDR:  seq_byte = idx_q ? 8'(start_w >> 8) : start_w[7:0];
         H_ADDR2: seq_byte = idx_q ? 8'(end_w >> 8) : end_w[7:0];
         default: seq_byte = 8'h00;
      endcase
   end

   // main sequence; waits on a wait count in power-up and the wp pulse, on seq_done in each pin state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q            <= H_PWRUP;
         wait_q          <= 16'(POWERUP_WAIT);
         idx_q           <= 1'b0;
         err_q           <= 1'b0;
         result_q        <= 8'h00;
         write_protect_n <= 1'b0;
         ce_n            <= 1'b1;
      end else if (clk_en) begin
         if (wait_q != 16'h0000) wait_q <= wait_q - 16'h0001;
         unique case (st_q)
            H_PWRUP: if (wait_q == 16'h0000) begin
               write_protect_n <= 1'b1;
               st_q            <= H_IDLE;
            end
            H_IDLE: if (go_q) begin
               idx_q <= 1'b0;
               err_q <= 1'b0;
               if (op_q == OP_WPPULSE) begin
                  write_protect_n <= 1'b0;
                  wait_q          <= 16'(WP_PULSE_CYC);
                  st_q            <= H_WP;
               end else if (op_q == OP_QUERY && !rb_s2_q) begin
                  err_q <= 1'b1;
               end else if (op_q == OP_UNLOCK && start_q > end_q) begin
                  err_q <= 1'b1;
               end else begin
                  ce_n <= 1'b0;
                  st_q <= H_CMD;
               end
            end
            H_WP: if (wait_q == 16'h0000) begin
               write_protect_n <= 1'b1;
               st_q            <= H_IDLE;
            end
            H_CMD: if (seq_done) begin
               if (op_q == OP_UNLOCK || op_q == OP_QUERY) st_q <= H_ADDR;
               else begin
                  ce_n <= 1'b1;
                  st_q <= H_IDLE;
               end
            end
            H_ADDR: if (seq_done) begin
               idx_q <= ~idx_q;
               if (idx_q) st_q <= (op_q == OP_QUERY) ? H_READ : H_CMD2;
            end
            H_CMD2: if (seq_done) st_q <= H_ADDR2;
            H_ADDR2: if (seq_done) begin
               idx_q <= ~idx_q;
               if (idx_q) begin
                  ce_n <= 1'b1;
                  st_q <= H_IDLE;
               end
            end
            H_READ: if (seq_done) begin
               result_q <= {5'h00, seq_rd[2:0]};
               ce_n     <= 1'b1;
               st_q     <= H_IDLE;
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end

   nand_pin_seq u_seq (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .start   (seq_start & ~seq_busy_q),
      .is_cmd  (seq_cmd),
      .is_read (seq_read),
      .byte_in (seq_byte),
      .io_sync (io_s2_q),
      .done    (seq_done),
      .rd_byte (seq_rd),
      .cle     (seq_cle),
      .ale     (seq_ale),
      .we_n    (seq_we),
      .re_n    (seq_re),
      .io_out  (seq_io),
      .io_oe   (seq_oe)
   );

   // blocks a second start while one pin cycle is in flight
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) seq_busy_q <= 1'b0;
      else if (clk_en) begin
         if (seq_done) seq_busy_q <= 1'b0;
         else if (seq_start) seq_busy_q <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cle             <= 1'b0;
         ale             <= 1'b0;
         we_n            <= 1'b1;
         read_enable_n   <= 1'b1;
         io_out          <= 8'h00;
         io_oe           <= 1'b0;
         lock_preset_pin <= 1'b1;
      end else if (clk_en) begin
         cle             <= seq_cle;
         ale             <= seq_ale;
         we_n            <= seq_we;
         read_enable_n   <= seq_re;
         io_out          <= seq_io;
         io_oe           <= seq_oe;
         lock_preset_pin <= preset_q;
      end
   end

   chk_wp_pulse_len: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(write_protect_n) && st_q == H_WP |-> !write_protect_n [*2])
      else $error("write protect pulse too short");
   chk_unlock_order: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && go_q && st_q == H_IDLE && op_q == OP_UNLOCK && start_q > end_q
      |=> st_q == H_IDLE && err_q)
      else $error("unlock with start above end issued");
   chk_busy_query: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && go_q && st_q == H_IDLE && op_q == OP_QUERY && !rb_s2_q
      |=> st_q == H_IDLE)
      else $error("lock status read issued while busy");
   chk_powerup_hold: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == H_PWRUP |-> !write_protect_n && ce_n)
      else $error("command before power-up wait");
endmodule : nand_lock_host
`default_nettype wire

// [tb/nand_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model
   import nand_lock_host_pkg::*;
(
   input  wire logic       cle,
   input  wire logic       ale,
   input  wire logic       ce_n,
   input  wire logic       we_n,
   input  wire logic       read_enable_n,
   input  wire logic       write_protect_n,
   input  wire logic       lock_preset_pin,
   input  wire logic       ext_busy,
   input  wire logic [7:0] io_out,
   output logic [7:0]      io_in,
   output logic            ready_busy_n
);
   logic        unl [2048];
   logic        tgt [2048];
   logic [7:0]  cmd;
   logic [7:0]  lo;
   logic [10:0] adr;
   logic [10:0] st;
   logic        nib;
   initial begin
      for (int i = 0; i < 2048; i++) begin
         unl[i] = 1'b0;
         tgt[i] = 1'b0;
      end
      cmd = 8'h00;
      lo = 8'h00;
      adr = 11'h000;
      st = 11'h000;
      nib = 1'b0;
      io_in = 8'h00;
   end
   // no program or erase here; busy comes only from a neighbour on the or-tied line
   assign ready_busy_n = !ext_busy;
   always @(negedge write_protect_n) begin
      for (int i = 0; i < 2048; i++) begin
         unl[i] = 1'b0;
         tgt[i] = 1'b0;
      end
   end
   always @(posedge we_n) if (!ce_n) begin
      if (cle) begin
         cmd = io_out;
         nib = 1'b0;
         if (lock_preset_pin && io_out == CMD_LOCK)
            for (int i = 0; i < 2048; i++) if (!tgt[i]) unl[i] = 1'b0;
         if (lock_preset_pin && io_out == CMD_LOCK_TIGHT)
            for (int i = 0; i < 2048; i++) if (!unl[i]) tgt[i] = 1'b1;
      end else if (ale) begin
         if (!nib) lo = io_out;
         else begin
            adr = {io_out[2:0], lo};
            if (cmd == CMD_UNLOCK_LO) st = adr;
            // tight blocks ignore the range; everything else outside it locks
            if (cmd == CMD_UNLOCK_HI && lock_preset_pin)
               for (int i = 0; i < 2048; i++)
                  if (!tgt[i]) unl[i] = (i >= st && i <= adr);
         end
         nib = !nib;
      end
   end
   // released bus toggles so a stale byte can never pass for status
   always #5 begin
      if (lock_preset_pin && cmd == CMD_LOCK_STATUS && !ce_n && !read_enable_n)
         io_in = {5'h00, unl[adr], !tgt[adr], tgt[adr]};
      else
         io_in = ~io_in;
   end
endmodule : nand_dev_model
`default_nettype wire

// [tb/nand_lock_host_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module nand_lock_host_tb_top;
   import nand_lock_host_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr, io_out, io_in;
   logic [31:0] pwdata, prdata, q;
   logic        cle, ale, ce_n, we_n, re_n, wp_n, pre, io_oe, rb_n, clk_en, ext_busy;
   int          fail_count, total_checks;
   nand_lock_host #(.POWERUP_WAIT(4)) dut_u (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n),
      .read_enable_n(re_n), .write_protect_n(wp_n), .lock_preset_pin(pre),
      .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .ready_busy_n(rb_n));
   nand_dev_model dev_u (
      .cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n), .read_enable_n(re_n),
      .write_protect_n(wp_n), .lock_preset_pin(pre), .io_out(io_out), .io_in(io_in),
      .ready_busy_n(rb_n), .ext_busy(ext_busy));
   always #50 pclk = ~pclk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic summarize();
      if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      err = pslverr;
      if (n >= 50) begin
         fail_count++;
         summarize();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // waits for the busy bit to clear; go while busy would be dropped
   task automatic op(input logic [2:0] code, input logic [10:0] s, input logic [10:0] e);
      int n;
      n = 0;
      apb(1'b1, REG_START, {21'h0, s});
      apb(1'b1, REG_END, {21'h0, e});
      apb(1'b1, REG_CTRL, {26'h0, 1'b1, 1'b0, code, 1'b1});
      repeat (2) @(posedge pclk);
      do begin
         apb(1'b0, REG_STATUS, 32'h0);
         n++;
      end while ((q[STAT_READY_BIT] !== 1'b1 || q[STAT_BUSY_BIT] !== 1'b0) && n < 300);
      if (n >= 300) begin
         fail_count++;
         summarize();
      end
   endtask : op
   task automatic qry(input logic [10:0] b, input logic [2:0] exp);
      op(OP_QUERY, b, b);
      apb(1'b0, REG_RESULT, 32'h0);
      check({29'h0, q[2:0]}, {29'h0, exp}, "block status");
   endtask : qry
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite} = 3'b000;
      paddr = 8'h00;
      pwdata = 32'h0;
      clk_en = 1'b1;
      ext_busy = 1'b0;
      fail_count = 0;
      total_checks = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check({31'h0, wp_n}, 32'h0, "wp during power-up");
      check({31'h0, pre}, 32'h1, "preset after reset");
      qry(11'd0, 3'b010);
      op(OP_UNLOCK, 11'd5, 11'd7);
      qry(11'd4, 3'b010);
      qry(11'd5, 3'b110);
      qry(11'd7, 3'b110);
      qry(11'd8, 3'b010);
      op(OP_UNLOCK, 11'd9, 11'd9);
      qry(11'd9, 3'b110);
      qry(11'd5, 3'b010);
      op(OP_UNLOCK, 11'd12, 11'd10);
      qry(11'd10, 3'b010);
      qry(11'd9, 3'b110);
      op(OP_TIGHT, 11'd0, 11'd0);
      qry(11'd0, 3'b001);
      qry(11'd9, 3'b110);
      op(OP_LOCK, 11'd0, 11'd0);
      qry(11'd9, 3'b010);
      op(OP_UNLOCK, 11'd0, 11'd3);
      qry(11'd1, 3'b001);
      op(OP_WPPULSE, 11'd0, 11'd0);
      qry(11'd1, 3'b010);
      op(OP_UNLOCK, 11'h7ff, 11'h7ff);
      qry(11'h7ff, 3'b110);
      qry(11'h7fe, 3'b010);
      ext_busy <= 1'b1;
      op(OP_QUERY, 11'h7ff, 11'h7ff);
      apb(1'b0, REG_RESULT, 32'h0);
      check(q, 32'h2, "result kept while busy");
      check({31'h0, ce_n}, 32'h1, "no command while busy");
      apb(1'b0, REG_STATUS, 32'h0);
      check({31'h0, q[STAT_RB_BIT]}, 32'h0, "busy line seen");
      ext_busy <= 1'b0;
      apb(1'b1, REG_CTRL, {26'h0, 1'b1, 1'b0, OP_WPPULSE, 1'b1});
      clk_en <= 1'b0;
      repeat (10) @(posedge pclk);
      check({31'h0, wp_n}, 32'h0, "wp held by clock enable");
      clk_en <= 1'b1;
      repeat (5) @(posedge pclk);
      check({31'h0, wp_n}, 32'h1, "wp pulse ends");
      apb(1'b0, 8'h20, 32'h0);
      check(q, 32'h0, "unmapped read data");
      check({31'h0, err}, 32'h1, "unmapped error");
      apb(1'b1, REG_CTRL, 32'h0);
      repeat (3) @(posedge pclk);
      check({31'h0, pre}, 32'h0, "preset cleared");
      summarize();
   end
endmodule : nand_lock_host_tb_top
`default_nettype wire
